/* File: rcpt_pkg.sv */
// Shared constants and types for the refresh command and rate pin tracker
package rcpt_pkg;

    // Command codes and register offsets on the serial bus
    localparam logic [7:0] CMD_GCALL_REFRESH = 8'h1E;
    localparam logic [7:0] CMD_KEEP_REFRESH = 8'h1F;
    localparam logic [7:0] CMD_PLAIN_REFRESH = 8'h00;
    localparam logic [7:0] REG_PIN_STATUS = 8'h20;
    localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

    // Device and general call addresses
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h10;
    localparam logic [7:0] GCALL_WRITE_BYTE = 8'h00;

    // Pin status register field positions
    localparam int PIN_LEVEL_BIT = 7;
    localparam int RISE_FLAG_BIT = 6;
    localparam int FALL_FLAG_BIT = 5;
    localparam int EDGE_EN_LSB = 1;
    localparam int POR_FLAG_BIT = 0;

    // Edge enables, high to low: rise full, rise keep, fall full, fall keep
    localparam logic [3:0] EDGE_EN_RESET = 4'hA;
    localparam int EN_RISE_FULL = 3;
    localparam int EN_RISE_KEEP = 2;
    localparam int EN_FALL_FULL = 1;
    localparam int EN_FALL_KEEP = 0;
    localparam logic POR_FLAG_RESET = 1'b1;

    // Bit count of a serial byte and warm-up of the pin edge detector
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] WARM_DONE = 2'h3;

    // Data widths of the result copies
    localparam int ACC_W = 48;
    localparam int CNT_W = 24;
    localparam int MEAS_W = 16;
    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_ACTIVE_RESET = 8'h00;

    // Serial slave states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACK_A = 7'h04,
        ST_WDATA = 7'h08,
        ST_ACK_W = 7'h10,
        ST_RDATA = 7'h20,
        ST_ACK_R = 7'h40
    } rcpt_bus_state_t;

endpackage

/* File: rcpt_refresh_if.sv */
// Refresh request carrier from the command decoder to the result snapshot
`timescale 1ns/1ps
interface rcpt_refresh_if;
    logic go;
    logic clr;
    logic act;

    modport src (output go, output clr, output act);
    modport dst (input go, input clr, input act);
endinterface

/* File: rcpt_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module rcpt_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Pins and their synchronised copies
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } rcpt_sync_state_t;

    rcpt_sync_state_t s_q;
    rcpt_sync_state_t s_d;

    // First stage feeds only the second stage
    always_comb
    begin
        s_d = s_q;
        s_d.stage1 = async_in;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sync_out = s_q.stage2;
endmodule

/* File: rcpt_snap.sv */
// Readable result copies and pending-to-active control transfer
`timescale 1ns/1ps
module rcpt_snap
    import rcpt_pkg::*;
#(
    parameter int AW = ACC_W,
    parameter int CW = CNT_W,
    parameter int MW = MEAS_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Refresh requests
    rcpt_refresh_if.dst rf,
    // Live measurement state
    input wire logic [AW-1:0] acc_live,
    input wire logic [CW-1:0] count_live,
    input wire logic [MW-1:0] bus_voltage_live,
    input wire logic [MW-1:0] sense_voltage_live,
    input wire logic [CTRL_W-1:0] ctrl_pending,
    // Readable copies and accumulator clear
    output logic [AW-1:0] acc_result,
    output logic [CW-1:0] count_result,
    output logic [MW-1:0] bus_voltage_result,
    output logic [MW-1:0] sense_voltage_result,
    output logic [CTRL_W-1:0] ctrl_active,
    output logic accum_clear
);
    typedef struct packed {
        logic [AW-1:0] acc;
        logic [CW-1:0] cnt;
        logic [MW-1:0] bus_voltage;
        logic [MW-1:0] sense_voltage;
        logic [CTRL_W-1:0] ctrl;
        logic clr;
    } rcpt_snap_state_t;

    rcpt_snap_state_t s_q;
    rcpt_snap_state_t s_d;

    // Copy on every refresh; only bus commands activate control settings
    always_comb
    begin
        s_d = s_q;
        s_d.clr = 1'b0;
        if (rf.go)
        begin
            s_d.acc = acc_live;
            s_d.cnt = count_live;
            s_d.bus_voltage = bus_voltage_live;
            s_d.sense_voltage = sense_voltage_live;
            s_d.clr = rf.clr;
        end
        if (rf.go && rf.act)
            s_d.ctrl = ctrl_pending;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.ctrl <= CTRL_ACTIVE_RESET;
        end
        else
            s_q <= s_d;
    end

    // Registered outputs
    assign acc_result = s_q.acc;
    assign count_result = s_q.cnt;
    assign bus_voltage_result = s_q.bus_voltage;
    assign sense_voltage_result = s_q.sense_voltage;
    assign ctrl_active = s_q.ctrl;
    assign accum_clear = s_q.clr;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Result copy and accumulator clear checks
    copy_on_go_a: assert property (rf.go |=> acc_result == $past(acc_live) && count_result == $past(count_live))
        else $error("result copy missed a refresh");
    keep_no_clear_a: assert property (rf.go && !rf.clr |=> !accum_clear)
        else $error("keep refresh cleared the accumulators");
    full_clears_a: assert property (rf.go && rf.clr |=> accum_clear)
        else $error("full refresh did not clear the accumulators");
    limited_no_act_a: assert property (!(rf.go && rf.act) |=> $stable(ctrl_active))
        else $error("control settings changed without a bus refresh");
endmodule

/* File: rcpt_core.sv */
// Serial command slave, rate pin status register and refresh launcher
`timescale 1ns/1ps
// Overview of operation
// - Send-byte 1EH refresh is accepted, including through the general call address.
// - 1EH copies results to readable registers and clears accumulators and count.
// - Send-byte 1FH updates readable results and leaves accumulators running.
// - Pin register at 20H updates in real time, without any refresh.
// - If both limited kinds are enabled on one edge, only the full one runs.
// - Both limited refreshes update results; only the full one clears accumulators.
// - Pin-edge refreshes never activate pending control settings.
// - With the pin used as alert output, the pin register reads zero.
// - Reading the pin register clears nothing.
// - Bit 7 shows the present pin level.
// - Bit 6 sets on a rising edge; only plain or general-call refresh or alert mode clears it.
// - Bit 5 sets on a falling edge; only plain or general-call refresh or alert mode clears it.
// - Bit 4 set enables full limited refresh on rising edges; resets to 1.
// - Bit 3 set enables keep limited refresh on rising edges; resets to 0.
// - Bit 2 set enables full limited refresh on falling edges; resets to 1.
// - Bit 1 set enables keep limited refresh on falling edges; resets to 0.
// - The four enable bits change only by host writes.
// - Bit 0 is 1 after power-on, cleared only by the host.
// - Pending control values become active only on serial-bus refresh commands.
module rcpt_core
    import rcpt_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
    parameter int AW = ACC_W,
    parameter int CW = CNT_W,
    parameter int MW = MEAS_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Rate-select pin and its alert-mode option
    input wire logic rate_pin,
    input wire logic pin_is_alert,
    // Live measurement state
    input wire logic [AW-1:0] acc_live,
    input wire logic [CW-1:0] count_live,
    input wire logic [MW-1:0] bus_voltage_live,
    input wire logic [MW-1:0] sense_voltage_live,
    input wire logic [CTRL_W-1:0] ctrl_pending,
    // Readable results
    output logic [AW-1:0] acc_result,
    output logic [CW-1:0] count_result,
    output logic [MW-1:0] bus_voltage_result,
    output logic [MW-1:0] sense_voltage_result,
    output logic [CTRL_W-1:0] ctrl_active,
    output logic accum_clear
);
    typedef struct packed {
        rcpt_bus_state_t st;
        logic [3:0] bitc;
        logic [7:0] shr;
        logic [7:0] ptr;
        logic first;
        logic gcall;
        logic rd;
        logic nack;
        logic drive;
        logic scl_prev;
        logic sda_prev;
        logic pin_prev;
        logic [1:0] warm;
        logic rise_flag;
        logic fall_flag;
        logic [3:0] edge_en;
        logic por;
        logic go;
        logic clr;
        logic act;
    } rcpt_core_state_t;

    rcpt_core_state_t s_q;
    rcpt_core_state_t s_d;
    logic scl_s;
    logic sda_s;
    logic pin_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic rise_ev;
    logic fall_ev;
    logic lim_full;
    logic lim_keep;
    logic bus_go;
    logic bus_clr;
    logic flag_clr;
    logic wr_pin;
    logic [7:0] pin_view_now;

    rcpt_refresh_if rf ();

    // Pin view, all zero in alert mode; reading has no side effect
    function automatic logic [7:0] pin_view(input rcpt_core_state_t s, input logic lvl, input logic alert);
        logic [7:0] v;
        v = '0;
        v[PIN_LEVEL_BIT] = lvl;
        v[RISE_FLAG_BIT] = s.rise_flag;
        v[FALL_FLAG_BIT] = s.fall_flag;
        v[EDGE_EN_LSB +: 4] = s.edge_en;
        v[POR_FLAG_BIT] = s.por;
        return alert ? READ_IDLE_VALUE : v;
    endfunction

    // Register read decode by pointer
    function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] view);
        return (ptr == REG_PIN_STATUS) ? view : READ_IDLE_VALUE;
    endfunction

    // Bus pins and rate pin pass two flip-flops first
    rcpt_sync #(.W(3)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({scl_in, sda_in, rate_pin}),
        .sync_out({scl_s, sda_s, pin_s})
    );

    // Bus conditions and pin edges from the synchronised copies
    assign scl_rise = scl_s & ~s_q.scl_prev;
    assign scl_fall = ~scl_s & s_q.scl_prev;
    assign bus_start = scl_s & s_q.scl_prev & ~sda_s & s_q.sda_prev;
    assign bus_stop = scl_s & s_q.scl_prev & sda_s & ~s_q.sda_prev;
    assign rise_ev = pin_s & ~s_q.pin_prev & (s_q.warm == WARM_DONE) & ~pin_is_alert;
    assign fall_ev = ~pin_s & s_q.pin_prev & (s_q.warm == WARM_DONE) & ~pin_is_alert;
    assign pin_view_now = pin_view(s_q, pin_s, pin_is_alert);

    // Full wins over keep on the same edge
    assign lim_full = (rise_ev & s_q.edge_en[EN_RISE_FULL]) | (fall_ev & s_q.edge_en[EN_FALL_FULL]);
    assign lim_keep = ~lim_full & ((rise_ev & s_q.edge_en[EN_RISE_KEEP]) |
        (fall_ev & s_q.edge_en[EN_FALL_KEEP]));

    // Next-state logic: serial slave, pin register and refresh launch
    always_comb
    begin
        s_d = s_q;
        bus_go = 1'b0;
        bus_clr = 1'b0;
        flag_clr = 1'b0;
        wr_pin = 1'b0;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        s_d.pin_prev = pin_s;
        if (s_q.warm != WARM_DONE)
            s_d.warm = 2'(s_q.warm + 2'h1);
        if (bus_start)
        begin
            s_d.st = ST_ADDR;
            s_d.bitc = '0;
            s_d.drive = 1'b0;
        end
        else if (bus_stop)
        begin
            s_d.st = ST_IDLE;
            s_d.drive = 1'b0;
        end
        else
        begin
            case (s_q.st)
                ST_IDLE:
                begin
                    s_d.drive = 1'b0;
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        s_d.shr = {s_q.shr[6:0], sda_s};
                        s_d.bitc = 4'(s_q.bitc + 4'h1);
                    end
                    else if (scl_fall && s_q.bitc == BYTE_BITS)
                    begin
                        if (s_q.shr[7:1] == DEV_ADDR)
                        begin
                            s_d.gcall = 1'b0;
                            s_d.rd = s_q.shr[0];
                            s_d.st = ST_ACK_A;
                            s_d.drive = 1'b1;
                        end
                        else if (s_q.shr == GCALL_WRITE_BYTE)
                        begin
                            s_d.gcall = 1'b1;
                            s_d.rd = 1'b0;
                            s_d.st = ST_ACK_A;
                            s_d.drive = 1'b1;
                        end
                        else
                            s_d.st = ST_IDLE;
                    end
                end
                ST_ACK_A:
                begin
                    if (scl_fall)
                    begin
                        s_d.bitc = '0;
                        if (s_q.rd)
                        begin
                            s_d.shr = reg_read(s_q.ptr, pin_view_now);
                            s_d.drive = ~s_d.shr[7];
                            s_d.st = ST_RDATA;
                        end
                        else
                        begin
                            s_d.drive = 1'b0;
                            s_d.first = 1'b1;
                            s_d.st = ST_WDATA;
                        end
                    end
                end
                ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        s_d.shr = {s_q.shr[6:0], sda_s};
                        s_d.bitc = 4'(s_q.bitc + 4'h1);
                    end
                    else if (scl_fall && s_q.bitc == BYTE_BITS)
                    begin
                        s_d.st = ST_ACK_W;
                        s_d.drive = 1'b1;
                        if (s_q.first)
                        begin
                            s_d.ptr = s_q.shr;
                            // Data-less send-byte commands act on the command byte
                            if (s_q.shr == CMD_GCALL_REFRESH ||
                                (!s_q.gcall && s_q.shr == CMD_PLAIN_REFRESH))
                            begin
                                bus_go = 1'b1;
                                bus_clr = 1'b1;
                                flag_clr = 1'b1;
                            end
                            else if (!s_q.gcall && s_q.shr == CMD_KEEP_REFRESH)
                                bus_go = 1'b1;
                        end
                        else if (!s_q.gcall && s_q.ptr == REG_PIN_STATUS)
                        begin
                            wr_pin = 1'b1;
                            s_d.edge_en = s_q.shr[EDGE_EN_LSB +: 4];
                            if (!s_q.shr[POR_FLAG_BIT])
                                s_d.por = 1'b0;
                        end
                    end
                end
                ST_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        s_d.drive = 1'b0;
                        s_d.bitc = '0;
                        s_d.first = 1'b0;
                        s_d.st = ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (s_q.bitc == LAST_TX_BIT)
                        begin
                            s_d.drive = 1'b0;
                            s_d.nack = 1'b0;
                            s_d.st = ST_ACK_R;
                        end
                        else
                        begin
                            s_d.shr = {s_q.shr[6:0], 1'b0};
                            s_d.drive = ~s_q.shr[6];
                            s_d.bitc = 4'(s_q.bitc + 4'h1);
                        end
                    end
                end
                ST_ACK_R:
                begin
                    if (scl_rise)
                        s_d.nack = sda_s;
                    else if (scl_fall)
                    begin
                        if (s_q.nack)
                            s_d.st = ST_IDLE;
                        else
                        begin
                            s_d.shr = reg_read(s_q.ptr, pin_view_now);
                            s_d.drive = ~s_d.shr[7];
                            s_d.bitc = '0;
                            s_d.st = ST_RDATA;
                        end
                    end
                end
                default:
                begin
                    s_d.st = ST_IDLE;
                    s_d.drive = 1'b0;
                end
            endcase
        end
        // Edge flags: an edge in the clearing cycle still sets
        if (flag_clr)
        begin
            s_d.rise_flag = 1'b0;
            s_d.fall_flag = 1'b0;
        end
        if (rise_ev)
            s_d.rise_flag = 1'b1;
        if (fall_ev)
            s_d.fall_flag = 1'b1;
        if (pin_is_alert)
        begin
            s_d.rise_flag = 1'b0;
            s_d.fall_flag = 1'b0;
        end
        // Bus refresh and limited refresh merge into one request
        s_d.go = bus_go | lim_full | lim_keep;
        s_d.clr = bus_clr | lim_full;
        s_d.act = bus_go;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.edge_en <= EDGE_EN_RESET;
            s_q.por <= POR_FLAG_RESET;
        end
        else
            s_q <= s_d;
    end

    // Open-drain data pin, driven low only
    assign sda_out = 1'b0;
    assign sda_oe = s_q.drive;
    assign rf.go = s_q.go;
    assign rf.clr = s_q.clr;
    assign rf.act = s_q.act;

    // Result copies and control activation
    rcpt_snap #(.AW(AW), .CW(CW), .MW(MW)) u_snap (
        .clock(clock),
        .sys_rst(sys_rst),
        .rf(rf),
        .acc_live(acc_live),
        .count_live(count_live),
        .bus_voltage_live(bus_voltage_live),
        .sense_voltage_live(sense_voltage_live),
        .ctrl_pending(ctrl_pending),
        .acc_result(acc_result),
        .count_result(count_result),
        .bus_voltage_result(bus_voltage_result),
        .sense_voltage_result(sense_voltage_result),
        .ctrl_active(ctrl_active),
        .accum_clear(accum_clear)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence rise_full_s;
        rise_ev && s_q.edge_en[EN_RISE_FULL];
    endsequence
    sequence fall_keep_only_s;
        fall_ev && !s_q.edge_en[EN_FALL_FULL] && s_q.edge_en[EN_FALL_KEEP];
    endsequence

    // Pin register and refresh launch checks
    rise_flag_set_a: assert property (rise_ev && !pin_is_alert |=> s_q.rise_flag || pin_is_alert)
        else $error("rising edge did not set its flag");
    fall_flag_set_a: assert property (fall_ev |=> s_q.fall_flag || pin_is_alert)
        else $error("falling edge did not set its flag");
    flag_only_clear_a: assert property ($fell(s_q.rise_flag) |-> $past(flag_clr) || $past(pin_is_alert))
        else $error("rise flag cleared without a clearing refresh");
    level_view_a: assert property (!pin_is_alert |-> pin_view_now[PIN_LEVEL_BIT] == pin_s)
        else $error("pin level bit disagrees with the pin");
    alert_zero_a: assert property (pin_is_alert |-> pin_view_now == READ_IDLE_VALUE)
        else $error("pin register not zero in alert mode");
    full_wins_a: assert property (rise_full_s ##0 !bus_go |=> s_q.go && s_q.clr && !s_q.act)
        else $error("full limited refresh not launched");
    fall_keep_a: assert property (fall_keep_only_s ##0 !bus_go |=> s_q.go && !s_q.clr)
        else $error("keep limited refresh wrong");
    enables_hold_a: assert property (!wr_pin |=> $stable(s_q.edge_en))
        else $error("edge enables changed without a write");
    por_clear_a: assert property ($fell(s_q.por) |-> $past(wr_pin) && !$past(s_q.shr[POR_FLAG_BIT]))
        else $error("power-on flag cleared without a zero write");
    por_no_set_a: assert property (!s_q.por |=> !s_q.por)
        else $error("power-on flag set again without reset");
    bus_act_a: assert property (bus_go |=> s_q.go && s_q.act ##1 ctrl_active == $past(ctrl_pending))
        else $error("bus refresh did not activate control settings");
endmodule

/* File: rcpt_host.sv */
// Serial bus host model driving clock and data lines
`timescale 1ns/1ps
module rcpt_host (
    // Open-drain bus lines
    output logic scl,
    output logic host_oe,
    input wire logic sda
);
    // Bus idles released
    initial
    begin
        scl = 1'b1;
        host_oe = 1'b0;
    end
    // One bit: data moves while clock low, sampled while high
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #50 host_oe = ~b;
        #50 scl = 1'b1;
        #50 r = sda;
        #50;
    endtask
    // Start: data falls with clock high
    task automatic start();
        host_oe = 1'b1;
        #100;
    endtask
    // Stop: data rises with clock high
    task automatic stop();
        scl = 1'b0;
        #50 host_oe = 1'b1;
        #50 scl = 1'b1;
        #50 host_oe = 1'b0;
        #100;
    endtask
    // Byte out MSB first, ninth bit left to the device
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Byte in MSB first, ended by a not-acknowledge
    task automatic rbyte(output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(1'b1, r);
    endtask
endmodule

/* File: rcpt_core_bench.sv */
// Self-checking bench for the refresh command and rate pin tracker
`timescale 1ns/1ps
module rcpt_core_bench
    import rcpt_pkg::*;
();
    localparam logic [7:0] WA = {DEV_ADDR_DEFAULT, 1'b0};
    logic clock = 0, sys_rst = 1, rate_pin = 0, pin_is_alert = 0;
    logic scl, host_oe, sda_oe, accum_clear;
    logic [103:0] live = '0, exp_res = '0;
    logic [7:0] ctrl_pending = 8'h00, ctrl_active, exp_ctrl = 8'h00, x;
    logic [7:0] cmds [3] = '{CMD_KEEP_REFRESH, CMD_PLAIN_REFRESH, CMD_GCALL_REFRESH};
    logic [3:0] e;
    logic [31:0] seed = 32'h7288;
    int bad_count = 0, n_tests = 0, n_clr = 0, c0;
    wire [103:0] res;
    wire sda = host_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    wire sda_out;
    rcpt_host host (.scl(scl), .host_oe(host_oe), .sda(sda));
    rcpt_core dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .rate_pin(rate_pin), .pin_is_alert(pin_is_alert), .acc_live(live[103:56]),
        .count_live(live[55:32]), .bus_voltage_live(live[31:16]), .sense_voltage_live(live[15:0]),
        .ctrl_pending(ctrl_pending), .acc_result(res[103:56]), .count_result(res[55:32]),
        .bus_voltage_result(res[31:16]), .sense_voltage_result(res[15:0]),
        .ctrl_active(ctrl_active), .accum_clear(accum_clear));
    // Clock and accumulator clear pulse count
    always #12.5 clock = ~clock;
    always @(posedge clock)
        if (accum_clear === 1'b1)
            n_clr++;
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [103:0] seen, input logic [103:0] want);
        n_tests++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    // New live values and pending control
    task automatic fresh();
        @(negedge clock);
        live = 104'({rnd(), rnd(), rnd(), rnd()});
        ctrl_pending = 8'(rnd());
    endtask
    // Write transfer, with or without a data byte
    task automatic cmd(input logic [7:0] a, input logic [7:0] c, input logic wd, input logic [7:0] d);
        logic ack;
        host.start();
        host.wbyte(a, ack);
        check(ack, 1'b1);
        host.wbyte(c, ack);
        if (wd)
            host.wbyte(d, ack);
        host.stop();
        repeat (8) @(negedge clock);
    endtask
    // Point at the pin register and read it
    task automatic rd20(input logic [7:0] want);
        logic [7:0] v;
        logic ack;
        cmd(WA, REG_PIN_STATUS, 1'b0, 8'h00);
        host.start();
        host.wbyte(WA | 8'h01, ack);
        host.rbyte(v);
        host.stop();
        check(v, want);
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog well past the expected run of about 1.3 ms
    initial
    begin
        #2000000;
        bad_count++;
        close_out();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        rd20(8'h15);
        for (int k = 0; k < 32; k++)
        begin
            e = 4'(k >> 1);
            cmd(WA, REG_PIN_STATUS, 1'b1, {3'h7, e, 1'b0});
            fresh();
            c0 = n_clr;
            rate_pin = ~rate_pin;
            if (rate_pin ? |e[3:2] : |e[1:0])
                exp_res = live;
            repeat (10) @(negedge clock);
            check(res, exp_res);
            check(n_clr - c0, rate_pin ? e[3] : e[1]);
            check(ctrl_active, exp_ctrl);
        end
        $display("edge refresh test done");
        cmd(WA, REG_PIN_STATUS, 1'b1, 8'hFF);
        for (int j = 0; j < 3; j++)
        begin
            rate_pin = ~rate_pin;
            repeat (8) @(negedge clock);
            fresh();
            c0 = n_clr;
            cmd(j == 2 ? GCALL_WRITE_BYTE : WA, cmds[j], 1'b0, 8'h00);
            check(res, live);
            check(ctrl_active, ctrl_pending);
            check(n_clr - c0, j != 0);
            x = {rate_pin, j == 0 ? 2'b11 : 2'b00, 5'h1E};
            rd20(x);
            rd20(x);
        end
        // Host waits a full millisecond; the results must still stand
        repeat (40000) @(negedge clock);
        check(res, live);
        $display("bus refresh test done");
        pin_is_alert = 1'b1;
        c0 = n_clr;
        rate_pin = ~rate_pin;
        rd20(8'h00);
        check(n_clr - c0, 0);
        $display("alert mode test done");
        // Second reset mid-run restores the power-on flag and enables
        sys_rst = 1'b1;
        pin_is_alert = 1'b0;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        check(ctrl_active, CTRL_ACTIVE_RESET);
        rd20(8'h15);
        $display("reset test done");
        close_out();
    end
endmodule
